// ==== core/pct_pkg.sv ====
// Purpose: constants for the two-channel 8-bit waveform timer
// Assumes: register port with one-cycle read latency, 200 MHz clock
// Notes:   channel clocks arrive as one-cycle tick inputs
package pct_pkg;
    localparam int          PCT_NCH      = 2;
    localparam int          PCT_AW       = 4;
    // register indices
    localparam logic [3:0]  PCT_A_ENABLE = 4'h0;
    localparam logic [3:0]  PCT_A_POL    = 4'h1;
    localparam logic [3:0]  PCT_A_ALIGN  = 4'h2;
    localparam logic [3:0]  PCT_A_CNT0   = 4'h4;
    localparam logic [3:0]  PCT_A_CNT1   = 4'h5;
    localparam logic [3:0]  PCT_A_PER0   = 4'h6;
    localparam logic [3:0]  PCT_A_PER1   = 4'h7;
    localparam logic [3:0]  PCT_A_DTY0   = 4'h8;
    localparam logic [3:0]  PCT_A_DTY1   = 4'h9;
    localparam logic [7:0]  PCT_RST_BYTE = 8'h00;
    localparam logic [7:0]  PCT_ONE      = 8'h01;
endpackage

// ==== core/pct_timer.sv ====
// Purpose: two-channel waveform timer core with register port
// Assumes: tick_in pulses are one clock wide, synchronous to clock
// Notes:   unmapped reads return zero, unmapped writes ignored
`timescale 1ns/1ps
module pct_timer
    import pct_pkg::*;
(
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   resetn,
    // register port
    input  wire logic [pct_pkg::PCT_AW-1:0] reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [7:0]             reg_rdata,
    // selected channel clock ticks
    input  wire logic [pct_pkg::PCT_NCH-1:0] tick_in,
    // waveforms
    output logic      [pct_pkg::PCT_NCH-1:0] channel_waveform_output
);
    import pct_pkg::*;

    logic                rst_meta_ff;
    logic                rst_sync_ff;
    logic                rstn;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    assign rstn = rst_sync_ff;

    // software state
    logic [PCT_NCH-1:0]  channel_enable_bit_ff, nxt_channel_enable_bit;
    logic [PCT_NCH-1:0]  start_polarity_bit_ff, nxt_start_polarity_bit;
    logic [PCT_NCH-1:0]  center_align_select_ff, nxt_center_align_select;
    logic [7:0]          per_buf_ff [PCT_NCH], nxt_per_buf [PCT_NCH];
    logic [7:0]          dty_buf_ff [PCT_NCH], nxt_dty_buf [PCT_NCH];
    // channel state
    logic [PCT_NCH-1:0]  run_ff, nxt_run;
    logic [7:0]          per_act_ff [PCT_NCH], nxt_per_act [PCT_NCH];
    logic [7:0]          dty_act_ff [PCT_NCH], nxt_dty_act [PCT_NCH];
    logic [7:0]          channel_counter_ff [PCT_NCH], nxt_channel_counter [PCT_NCH];
    logic [PCT_NCH-1:0]  down_ff, nxt_down;
    logic [PCT_NCH-1:0]  flop_ff, nxt_flop;
    logic [PCT_NCH-1:0]  zero_pend_ff, nxt_zero_pend;
    logic [PCT_NCH-1:0]  wave_ff, nxt_wave;
    logic [7:0]          rdata_ff, nxt_rdata;

    function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] base, input int ch);
        wr_hit = (a == base + 4'(ch));
    endfunction

    always_comb begin
        logic cnt_wr;
        logic per_wr;
        logic dty_wr;
        logic tick;
        logic load;
        logic [7:0] c;
        cnt_wr = 1'b0;
        per_wr = 1'b0;
        dty_wr = 1'b0;
        tick   = 1'b0;
        load   = 1'b0;
        c      = 8'h00;
        nxt_channel_enable_bit  = channel_enable_bit_ff;
        nxt_start_polarity_bit  = start_polarity_bit_ff;
        nxt_center_align_select = center_align_select_ff;
        nxt_run                 = run_ff;
        nxt_down                = down_ff;
        nxt_flop                = flop_ff;
        nxt_zero_pend           = zero_pend_ff;
        if (reg_wr && reg_addr == PCT_A_ENABLE) begin
            nxt_channel_enable_bit = reg_wdata[PCT_NCH-1:0];
        end
        if (reg_wr && reg_addr == PCT_A_POL) begin
            nxt_start_polarity_bit = reg_wdata[PCT_NCH-1:0];
        end
        if (reg_wr && reg_addr == PCT_A_ALIGN) begin
            nxt_center_align_select = reg_wdata[PCT_NCH-1:0];
        end
        for (int i = 0; i < PCT_NCH; i++) begin
            cnt_wr = reg_wr && wr_hit(reg_addr, PCT_A_CNT0, i);
            per_wr = reg_wr && wr_hit(reg_addr, PCT_A_PER0, i);
            dty_wr = reg_wr && wr_hit(reg_addr, PCT_A_DTY0, i);
            nxt_per_buf[i]         = per_wr ? reg_wdata : per_buf_ff[i];
            nxt_dty_buf[i]         = dty_wr ? reg_wdata : dty_buf_ff[i];
            nxt_per_act[i]         = per_act_ff[i];
            nxt_dty_act[i]         = dty_act_ff[i];
            nxt_channel_counter[i] = channel_counter_ff[i];
            // enable takes effect on a channel tick edge
            if (tick_in[i]) begin
                nxt_run[i] = channel_enable_bit_ff[i];
            end
            tick = tick_in[i] && run_ff[i];
            c    = channel_counter_ff[i];
            if (!run_ff[i]) begin
                // latches follow buffers while stopped
                nxt_per_act[i] = nxt_per_buf[i];
                nxt_dty_act[i] = nxt_dty_buf[i];
                if (per_wr && reg_wdata == 8'h00) begin
                    nxt_zero_pend[i] = 1'b1;
                end
                if (zero_pend_ff[i] && tick_in[i]) begin
                    nxt_channel_counter[i] = 8'h00;
                    nxt_zero_pend[i]       = 1'b0;
                end
            end else if (tick) begin
                nxt_zero_pend[i] = 1'b0;
                if (per_act_ff[i] == 8'h00) begin
                    nxt_channel_counter[i] = 8'h00;
                    nxt_down[i]            = 1'b0;
                    nxt_flop[i]            = 1'b0;
                    load                   = 1'b1;
                end else if (!center_align_select_ff[i]) begin
                    // left aligned: 0 .. period-1
                    if (c + PCT_ONE >= per_act_ff[i]) begin
                        nxt_channel_counter[i] = 8'h00;
                        nxt_flop[i]            = 1'b0;
                        load                   = 1'b1;
                    end else begin
                        nxt_channel_counter[i] = c + PCT_ONE;
                        if (c + PCT_ONE == dty_act_ff[i]) begin
                            nxt_flop[i] = ~flop_ff[i];
                        end
                    end
                    nxt_down[i] = 1'b0;
                end else begin
                    // center aligned: 0 up to period, back to 0
                    if (!down_ff[i] && c >= per_act_ff[i]) begin
                        nxt_down[i] = 1'b1;
                    end
                    if ((down_ff[i] || c >= per_act_ff[i]) && c != 8'h00) begin
                        nxt_channel_counter[i] = c - PCT_ONE;
                        if (c - PCT_ONE == dty_act_ff[i]) begin
                            nxt_flop[i] = ~flop_ff[i];
                        end
                        if (c == PCT_ONE) begin
                            nxt_down[i] = 1'b0;
                            nxt_flop[i] = 1'b0;
                            load        = 1'b1;
                        end
                    end else begin
                        nxt_down[i]            = 1'b0;
                        nxt_channel_counter[i] = c + PCT_ONE;
                        if (c + PCT_ONE == dty_act_ff[i]) begin
                            nxt_flop[i] = ~flop_ff[i];
                        end
                    end
                end
                if (load) begin
                    nxt_per_act[i] = per_buf_ff[i];
                    nxt_dty_act[i] = dty_buf_ff[i];
                end
                load = 1'b0;
            end
            if (cnt_wr) begin
                nxt_channel_counter[i] = 8'h00;
                nxt_down[i]            = 1'b0;
                nxt_flop[i]            = 1'b0;
                nxt_per_act[i]         = nxt_per_buf[i];
                nxt_dty_act[i]         = nxt_dty_buf[i];
                nxt_zero_pend[i]       = 1'b0;
            end
            // disabled channel freezes count, direction, flop, except a counter write clears all three and a pending zero period clears count on a tick
            nxt_wave[i] = (nxt_per_act[i] == 8'h00) ? nxt_start_polarity_bit[i]
                : (nxt_flop[i] ^ nxt_start_polarity_bit[i]);
        end
        // held count survives enable toggling; reset values below
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                PCT_A_ENABLE: nxt_rdata = {6'h00, channel_enable_bit_ff};
                PCT_A_POL:    nxt_rdata = {6'h00, start_polarity_bit_ff};
                PCT_A_ALIGN:  nxt_rdata = {6'h00, center_align_select_ff};
                PCT_A_CNT0:   nxt_rdata = channel_counter_ff[0];
                PCT_A_CNT1:   nxt_rdata = channel_counter_ff[1];
                PCT_A_PER0:   nxt_rdata = per_buf_ff[0];
                PCT_A_PER1:   nxt_rdata = per_buf_ff[1];
                PCT_A_DTY0:   nxt_rdata = dty_buf_ff[0];
                PCT_A_DTY1:   nxt_rdata = dty_buf_ff[1];
                default:      nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            channel_enable_bit_ff  <= '0;
            start_polarity_bit_ff  <= '0;
            center_align_select_ff <= '0;
            run_ff                 <= '0;
            down_ff                <= '0;
            flop_ff                <= '0;
            zero_pend_ff           <= '0;
            wave_ff                <= '0;
            rdata_ff               <= PCT_RST_BYTE;
            for (int i = 0; i < PCT_NCH; i++) begin
                per_buf_ff[i]         <= PCT_RST_BYTE;
                dty_buf_ff[i]         <= PCT_RST_BYTE;
                per_act_ff[i]         <= PCT_RST_BYTE;
                dty_act_ff[i]         <= PCT_RST_BYTE;
                channel_counter_ff[i] <= PCT_RST_BYTE;
            end
        end else begin
            channel_enable_bit_ff  <= nxt_channel_enable_bit;
            start_polarity_bit_ff  <= nxt_start_polarity_bit;
            center_align_select_ff <= nxt_center_align_select;
            run_ff                 <= nxt_run;
            down_ff                <= nxt_down;
            flop_ff                <= nxt_flop;
            zero_pend_ff           <= nxt_zero_pend;
            wave_ff                <= nxt_wave;
            rdata_ff               <= nxt_rdata;
            for (int i = 0; i < PCT_NCH; i++) begin
                per_buf_ff[i]         <= nxt_per_buf[i];
                dty_buf_ff[i]         <= nxt_dty_buf[i];
                per_act_ff[i]         <= nxt_per_act[i];
                dty_act_ff[i]         <= nxt_dty_act[i];
                channel_counter_ff[i] <= nxt_channel_counter[i];
            end
        end
    end

    assign reg_rdata               = rdata_ff;
    assign channel_waveform_output = wave_ff;
endmodule

// ==== testbench/pct_timer_props.sv ====
// Purpose: port-level checks for the waveform timer
// Assumes: register strobes one cycle wide, never together
// Notes:   bound to every pct_timer instance
`timescale 1ns/1ps
module pct_timer_chk
    import pct_pkg::*;
(
    input wire logic               clock,
    input wire logic               resetn,
    input wire logic [pct_pkg::PCT_AW-1:0]  reg_addr,
    input wire logic [7:0]         reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [7:0]         reg_rdata,
    input wire logic [pct_pkg::PCT_NCH-1:0] tick_in,
    input wire logic [pct_pkg::PCT_NCH-1:0] channel_waveform_output
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // quiet register accesses on channel 0
    sequence s_wr(a); reg_wr && reg_addr == a && !tick_in[0]; endsequence
    sequence s_rd(a); reg_rd && reg_addr == a && !tick_in[0]; endsequence
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    AST_CNT_CLR: assert property (s_wr(PCT_A_CNT0) ##1 s_rd(PCT_A_CNT0) |=> reg_rdata == 8'h00)
        else $error("counter not cleared by write");
    AST_PER_BUF: assert property (s_wr(PCT_A_PER0) ##1 s_rd(PCT_A_PER0)
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("period buffer readback wrong");
    AST_POL_BACK: assert property (s_wr(PCT_A_POL) ##1 s_rd(PCT_A_POL)
        |=> reg_rdata[1:0] == $past(reg_wdata[1:0], 2))
        else $error("polarity readback wrong");
    AST_RD_KEEP: assert property (s_rd(PCT_A_CNT0) ##1 s_rd(PCT_A_CNT0) |=> $stable(reg_rdata))
        else $error("counter read disturbed the count");
    AST_WAVE_CAUSE: assert property ($changed(channel_waveform_output[0])
        |-> $past(tick_in[0] || reg_wr))
        else $error("waveform moved without tick or write");
    AST_UNMAP: assert property (reg_rd && reg_addr == 4'h3 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_RST_OUT: assert property (disable iff (1'b0) !resetn |-> channel_waveform_output == '0)
        else $error("waveform not low in reset");
endmodule

bind pct_timer pct_timer_chk i_chk (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tick_in(tick_in), .channel_waveform_output(channel_waveform_output));

// ==== testbench/tb.sv ====
// Purpose: directed bench for the two-channel waveform timer
// Assumes: bench drives channel ticks in place of the clock divider
// Notes:   one task per scenario, judged inline
`timescale 1ns/1ps
module tb;
    import pct_pkg::*;
    logic               clock;
    logic               resetn;
    logic [PCT_AW-1:0]  reg_addr;
    logic [7:0]         reg_wdata;
    logic               reg_wr;
    logic               reg_rd;
    logic [7:0]         reg_rdata;
    logic [PCT_NCH-1:0] tick_in;
    logic [PCT_NCH-1:0] wave;
    int                 errors;
    int                 checks_done;
    logic [7:0]         v;
    logic [7:0]         w;

    pct_timer i_dut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tick_in(tick_in), .channel_waveform_output(wave));

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        #1;
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        #1;
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic tick(input int ch);
        #1;
        tick_in[ch] <= 1'b1;
        @(posedge clock);
        tick_in[ch] <= 1'b0;
        #1;
    endtask
    // pat bit i is the level expected after tick i
    task automatic run(input int ch, input int n, input logic [15:0] pat, input string nm);
        for (int i = 0; i < n; i++) begin
            tick(ch);
            chk(nm, {7'h00, pat[i]}, {7'h00, wave[ch]});
        end
    endtask
    task automatic t_reset;
        chk("wave", 8'h00, {6'h00, wave});
        rd(PCT_A_ENABLE, v);
        chk("enable", 8'h00, v);
        rd(PCT_A_CNT0, v);
        chk("count0", 8'h00, v);
        rd(4'h3, v);
        chk("unmapped", 8'h00, v);
        $display("test reset done");
    endtask
    task automatic t_left;
        wr(PCT_A_POL, 8'h00);
        wr(PCT_A_ALIGN, 8'h00);
        wr(PCT_A_PER0, 8'h04);
        wr(PCT_A_DTY0, 8'h01);
        wr(PCT_A_CNT0, 8'h00);
        wr(PCT_A_ENABLE, 8'h01);
        tick(0);
        run(0, 5, 16'h0017, "left wave");
        rd(PCT_A_CNT0, v);
        chk("left count", 8'h01, v);
        wr(PCT_A_PER0, 8'h02);
        rd(PCT_A_PER0, v);
        chk("period buffer", 8'h02, v);
        run(0, 5, 16'h000b, "buffered wave");
        run(0, 1, 16'h0001, "pre write wave");
        wr(PCT_A_CNT0, 8'h5a);
        #1;
        chk("write level", 8'h00, {7'h00, wave[0]});
        rd(PCT_A_CNT0, v);
        rd(PCT_A_CNT0, w);
        chk("cleared count", 8'h00, v);
        chk("reread count", 8'h00, w);
        run(0, 1, 16'h0001, "restart wave");
        wr(PCT_A_ENABLE, 8'h00);
        tick(0);
        rd(PCT_A_CNT0, v);
        repeat (3) tick(0);
        rd(PCT_A_CNT0, w);
        chk("held count", v, w);
        $display("test left done");
    endtask
    task automatic t_center;
        wr(PCT_A_POL, 8'h02);
        rd(PCT_A_POL, v);
        chk("polarity", 8'h02, v & 8'h03);
        wr(PCT_A_ALIGN, 8'h02);
        wr(PCT_A_PER1, 8'h04);
        wr(PCT_A_DTY1, 8'h01);
        wr(PCT_A_CNT1, 8'h00);
        #1;
        chk("start level", 8'h01, {7'h00, wave[1]});
        wr(PCT_A_ENABLE, 8'h02);
        tick(1);
        run(1, 9, 16'h00c0, "center wave");
        wr(PCT_A_ENABLE, 8'h00);
        tick(1);
        wr(PCT_A_PER1, 8'h00);
        tick(1);
        rd(PCT_A_CNT1, v);
        chk("zero period count", 8'h00, v);
        chk("zero period level", 8'h01, {7'h00, wave[1]});
        $display("test center done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        errors      = 0;
        checks_done = 0;
        resetn      = 1'b0;
        reg_addr    = '0;
        reg_wdata   = '0;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        tick_in     = '0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        t_reset;
        t_left;
        t_center;
        wrap_up;
    end
    // tests need about 60 cycles; allow 4000
    initial begin
        #20000;
        errors++;
        wrap_up;
    end
endmodule
